// file: tx_test_cfg.svh
// constants for the transmit test-mode generator
`ifndef TX_TEST_CFG_SVH
`define TX_TEST_CFG_SVH
`define CLK_PERIOD_NS 10
`define SYMBOL_PERIOD_NS 8
`define SYMBOL_CYCLES ((`SYMBOL_PERIOD_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`SYMBOL_PERIOD_NS / `CLK_PERIOD_NS))
`define MODE_FIELD_W 3
`define MODE_NORMAL 3'h0
`define MODE_TEST1 3'h1
`define MODE_TEST2 3'h2
`define MODE_TEST3 3'h3
`define MODE_TEST4 3'h4
`define SCR_W 11
`define SCR_TAP_A 8
`define SCR_TAP_B 10
`define SCR_SEED 11'h7FF
`define SYM_POS2 3'h2
`define SYM_NEG2 3'h6
`define SYM_ZERO 3'h0
`define SYM_POS1 3'h1
`define SYM_NEG1 3'h7
`define T1_DEPTH 16
`endif

// file: tx_test_pkg.sv
// types for the transmit test-mode generator
package tx_test_pkg;
  // one quinary symbol, two's complement -2..+2
  typedef logic [2:0] symbol_type;
  // symbols for the four transmitters
  typedef struct packed {
    symbol_type pair_d;
    symbol_type pair_c;
    symbol_type pair_b;
    symbol_type pair_a;
  } symbol_quad_type;
  // transmit source selection, one-hot
  typedef enum logic [4:0] {
    MODE_NORMAL_SEL = 5'b00001,
    MODE_T1_SEL = 5'b00010,
    MODE_T2_SEL = 5'b00100,
    MODE_T3_SEL = 5'b01000,
    MODE_T4_SEL = 5'b10000
  } mode_type;
endpackage

// file: tx_test_mode_generator.sv
// transmit test-mode symbol generator for a four-pair physical_layer_device
`timescale 1ns/10ps
`default_nettype none
`include "tx_test_cfg.svh"

// Function
// - With management present, a three-bit control field picks the test mode.
// - Test modes swap the symbols fed to the transmit path and also force the timing role.
// - Without management, pins offer another way to turn test modes on.
// - Mode 1 sends its fixed sequence nonstop on all four transmitters.
// - Mode 1 runs on the local symbol timing with master timing.
// - Mode 2 repeats +2 then -2 on all four channels.
// - Mode 2 runs on the local symbol timing with master timing.
// - Mode 3 repeats +2 then -2 on all four channels with slave timing.
// - Mode 4 sends symbols derived from the scrambler instead of data.
// - Mode 4 forms three bit streams from scrambler bits and maps them.
// - The mode 4 shift register steps once per symbol period.
// - Mode 4 drives the same symbol to all four transmitters at once.
// - Mode 4 runs on the local symbol timing with master timing.
// - The symbol clock that times transmission is brought out.
// - A control turns the symbol clock output on when needed.
module tx_test_mode_generator #(
  parameter bit HAS_MGMT = 1'b1,
  parameter int T1_DEPTH = `T1_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`MODE_FIELD_W-1:0] mgmt_test_mode,
  input wire logic pin_test_mode_enable,
  input wire logic [`MODE_FIELD_W-1:0] pin_test_mode_select,
  input wire logic pin_clock_out_enable,
  input wire logic normal_timing_master,
  input wire tx_test_pkg::symbol_quad_type normal_symbols,
  output tx_test_pkg::symbol_quad_type tx_symbols,
  output logic timing_master,
  output logic test_active,
  output logic mode_reserved,
  output logic tx_symbol_clock_out
);
  import tx_test_pkg::*;

  localparam int SYM_CYC = `SYMBOL_CYCLES;
  localparam int CNT_W = (SYM_CYC > 1) ? $clog2(SYM_CYC) : 1;
  localparam int IDX_W = (T1_DEPTH > 1) ? $clog2(T1_DEPTH) : 1;

  // mode field to one-hot source, reserved codes fall back to normal
  function automatic mode_type decode_mode(
    input logic [`MODE_FIELD_W-1:0] field
  );
    case (field)
      `MODE_TEST1: decode_mode = MODE_T1_SEL;
      `MODE_TEST2: decode_mode = MODE_T2_SEL;
      `MODE_TEST3: decode_mode = MODE_T3_SEL;
      `MODE_TEST4: decode_mode = MODE_T4_SEL;
      default: decode_mode = MODE_NORMAL_SEL;
    endcase
  endfunction

  // three scrambler streams to one quinary symbol
  function automatic symbol_type map_quinary(input logic [2:0] xbits);
    case (xbits)
      3'h0: map_quinary = `SYM_ZERO;
      3'h1: map_quinary = `SYM_POS1;
      3'h2: map_quinary = `SYM_POS2;
      3'h3: map_quinary = `SYM_NEG1;
      3'h4: map_quinary = `SYM_ZERO;
      3'h5: map_quinary = `SYM_POS1;
      3'h6: map_quinary = `SYM_NEG2;
      default: map_quinary = `SYM_NEG1;
    endcase
  endfunction

  // mode 1 pattern table
  function automatic symbol_type t1_entry(input logic [IDX_W-1:0] idx);
    case (idx)
      4'h0: t1_entry = `SYM_POS2;
      4'h4: t1_entry = `SYM_NEG2;
      4'h8: t1_entry = `SYM_POS1;
      4'hC: t1_entry = `SYM_NEG1;
      default: t1_entry = `SYM_ZERO;
    endcase
  endfunction

  // pin inputs pass two flip-flops
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end
    else
    begin
      pin_meta <= {pin_clock_out_enable, pin_test_mode_enable,
                   pin_test_mode_select};
      pin_sync <= pin_meta;
    end
  end

  logic [`MODE_FIELD_W-1:0] field;
  logic clock_out_en;
  // field source: management or pins
  always_comb
  begin
    if (HAS_MGMT)
      field = mgmt_test_mode;
    else
      field = pin_sync[3] ? pin_sync[2:0] : `MODE_NORMAL;
    clock_out_en = pin_sync[4];
  end

  // state
  mode_type mode;
  logic [CNT_W-1:0] sym_cnt;
  logic sym_en;
  logic [IDX_W-1:0] t1_idx;
  logic alt_phase;
  logic [`SCR_W-1:0] scr;
  logic sym_clk;
  mode_type next_mode;
  logic [CNT_W-1:0] next_sym_cnt;
  logic [IDX_W-1:0] next_t1_idx;
  logic next_alt_phase;
  logic [`SCR_W-1:0] next_scr;
  logic next_sym_clk;
  symbol_quad_type next_tx_symbols;
  logic next_timing_master;
  symbol_type test_sym;
  logic next_test_active;
  logic next_mode_reserved;
  logic next_clock_out;

  // symbol enable divider and pattern sequencers
  always_comb
  begin
    next_mode = decode_mode(field);
    sym_en = (sym_cnt == CNT_W'(SYM_CYC - 1));
    next_sym_cnt = sym_en ? '0 : sym_cnt + 1'b1;
    next_t1_idx = t1_idx;
    next_alt_phase = alt_phase;
    next_scr = scr;
    // symbol clock keeps toggling across mode changes
    next_sym_clk = sym_en ? ~sym_clk : sym_clk;
    if (next_mode != mode)
    begin
      next_t1_idx = '0;
      next_alt_phase = 1'b0;
      next_scr = `SCR_SEED;
    end
    else if (sym_en)
    begin
      if (t1_idx == IDX_W'(T1_DEPTH - 1))
        next_t1_idx = '0;
      else
        next_t1_idx = t1_idx + 1'b1;
      next_alt_phase = ~alt_phase;
      if (mode == MODE_T4_SEL)
        next_scr = {scr[`SCR_W-2:0],
                    scr[`SCR_TAP_A] ^ scr[`SCR_TAP_B]};
    end
  end

  // symbol selection and timing role
  always_comb
  begin
    test_sym = `SYM_ZERO;
    next_tx_symbols = tx_symbols;
    next_timing_master = normal_timing_master;
    unique case (mode)
      MODE_NORMAL_SEL: test_sym = `SYM_ZERO;
      MODE_T1_SEL: test_sym = t1_entry(t1_idx);
      MODE_T2_SEL: test_sym = alt_phase ? `SYM_NEG2 : `SYM_POS2;
      MODE_T3_SEL: test_sym = alt_phase ? `SYM_NEG2 : `SYM_POS2;
      MODE_T4_SEL: test_sym = map_quinary({scr[2] ^ scr[6],
                                 scr[1] ^ scr[4], scr[0]});
    endcase
    if (mode == MODE_T3_SEL)
      next_timing_master = 1'b0;
    else if (mode != MODE_NORMAL_SEL)
      next_timing_master = 1'b1;
    if (sym_en)
    begin
      if (mode == MODE_NORMAL_SEL)
        next_tx_symbols = normal_symbols;
      else
        next_tx_symbols = '{test_sym, test_sym, test_sym, test_sym};
    end
    next_test_active = (next_mode != MODE_NORMAL_SEL);
    next_mode_reserved = (field > `MODE_TEST4);
    next_clock_out = next_sym_clk & clock_out_en;
  end

  // registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= MODE_NORMAL_SEL;
      sym_cnt <= '0;
      t1_idx <= '0;
      alt_phase <= 1'b0;
      scr <= `SCR_SEED;
      sym_clk <= 1'b0;
      tx_symbols <= '0;
      timing_master <= 1'b0;
      test_active <= 1'b0;
      mode_reserved <= 1'b0;
      tx_symbol_clock_out <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      sym_cnt <= next_sym_cnt;
      t1_idx <= next_t1_idx;
      alt_phase <= next_alt_phase;
      scr <= next_scr;
      sym_clk <= next_sym_clk;
      tx_symbols <= next_tx_symbols;
      timing_master <= next_timing_master;
      test_active <= next_test_active;
      mode_reserved <= next_mode_reserved;
      tx_symbol_clock_out <= next_clock_out;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_t2_steady;
    mode == MODE_T2_SEL && $stable(mode) && sym_en;
  endsequence

  AST_ALL_PAIRS_EQUAL: assert property (
    mode != MODE_NORMAL_SEL && $past(mode) == mode ##1 1'b1
    |-> tx_symbols.pair_a == tx_symbols.pair_b
        && tx_symbols.pair_b == tx_symbols.pair_c
        && tx_symbols.pair_c == tx_symbols.pair_d)
    else $error("pairs differ in test mode");
  AST_T2_ALTERNATES: assert property (
    s_t2_steady ##1 (mode == MODE_T2_SEL && sym_en)
    |=> tx_symbols.pair_a != $past(tx_symbols.pair_a))
    else $error("mode 2 does not alternate");
  AST_T2_LEVELS: assert property (
    s_t2_steady |=> tx_symbols.pair_a == `SYM_POS2
                    || tx_symbols.pair_a == `SYM_NEG2)
    else $error("mode 2 symbol not +2 or -2");
  AST_T3_SLAVE: assert property (
    mode == MODE_T3_SEL |=> !timing_master)
    else $error("mode 3 not slave timing");
  AST_T1_MASTER: assert property (
    mode == MODE_T1_SEL |=> timing_master)
    else $error("mode 1 not master timing");
  AST_T4_MASTER: assert property (
    mode == MODE_T4_SEL |=> timing_master)
    else $error("mode 4 not master timing");
  AST_SCR_STEP: assert property (
    mode == MODE_T4_SEL && next_mode == mode && sym_en
    |=> scr == {$past(scr[`SCR_W-2:0]),
                $past(scr[`SCR_TAP_A]) ^ $past(scr[`SCR_TAP_B])})
    else $error("scrambler step wrong");
  AST_T1_WRAP: assert property (
    mode == MODE_T1_SEL && next_mode == mode && sym_en
    && t1_idx == IDX_W'(T1_DEPTH - 1) |=> t1_idx == '0)
    else $error("mode 1 table did not restart");
  AST_NORMAL_PASS: assert property (
    mode == MODE_NORMAL_SEL && sym_en |=> tx_symbols == $past(normal_symbols))
    else $error("normal symbols not passed");
  AST_CLK_GATE: assert property (
    !clock_out_en |=> !tx_symbol_clock_out)
    else $error("clock out while disabled");
  AST_SYM_CLK_TOGGLE: assert property (
    sym_en |=> sym_clk != $past(sym_clk))
    else $error("symbol clock missed a toggle");
  AST_RESERVED_NORMAL: assert property (
    field > `MODE_TEST4 |=> mode_reserved && !test_active)
    else $error("reserved code not treated as normal");
endmodule // tx_test_mode_generator
`default_nettype wire

// file: tx_line_tester.sv
// medium-side tester model watching the four transmitters
`timescale 1ns/10ps
`default_nettype none
module tx_line_tester (
  input wire tx_test_pkg::symbol_quad_type tx_symbols,
  output logic pairs_equal
);
  import tx_test_pkg::*;
  // high when all four pairs carry one symbol
  assign pairs_equal = (tx_symbols.pair_a === tx_symbols.pair_b) &&
    (tx_symbols.pair_a === tx_symbols.pair_c) &&
    (tx_symbols.pair_a === tx_symbols.pair_d);
endmodule // tx_line_tester
`default_nettype wire

// file: testbench.sv
// self-checking bench for the transmit test-mode generator
`timescale 1ns/10ps
`default_nettype none
`include "tx_test_cfg.svh"
module testbench;
  import tx_test_pkg::*;
  logic clk, rst_n, pin_en, pin_clk_en, norm_master, master, active;
  logic reserved, clk_out, pairs_equal;
  logic [2:0] mgmt_mode, pin_sel;
  logic [10:0] scr;
  symbol_quad_type norm_sym, tx_sym, pin_sym;
  int mismatches, check_count, cycles;
  // management-driven and pin-driven instances
  tx_test_mode_generator #(.HAS_MGMT(1'b1)) dut_u (.clk(clk),
    .rst_n(rst_n), .mgmt_test_mode(mgmt_mode), .pin_test_mode_enable(pin_en),
    .pin_test_mode_select(pin_sel), .pin_clock_out_enable(pin_clk_en),
    .normal_timing_master(norm_master), .normal_symbols(norm_sym),
    .tx_symbols(tx_sym), .timing_master(master), .test_active(active),
    .mode_reserved(reserved), .tx_symbol_clock_out(clk_out));
  tx_test_mode_generator #(.HAS_MGMT(1'b0)) dut_pin_u (.clk(clk),
    .rst_n(rst_n), .mgmt_test_mode(mgmt_mode), .pin_test_mode_enable(pin_en),
    .pin_test_mode_select(pin_sel), .pin_clock_out_enable(pin_clk_en),
    .normal_timing_master(norm_master), .normal_symbols(norm_sym),
    .tx_symbols(pin_sym), .timing_master(), .test_active(),
    .mode_reserved(), .tx_symbol_clock_out());
  tx_line_tester tester_u (.tx_symbols(tx_sym), .pairs_equal(pairs_equal));
  // free-running clock and hang limit
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [11:0] quad(input logic [2:0] s);
    return {4{s}};
  endfunction
  // mode 1 table entry and mode 4 symbol mapping
  function automatic logic [2:0] t1_sym(input int i);
    case (i)
      0: return `SYM_POS2;
      4: return `SYM_NEG2;
      8: return `SYM_POS1;
      12: return `SYM_NEG1;
      default: return `SYM_ZERO;
    endcase
  endfunction
  function automatic logic [2:0] scr_sym(input logic [10:0] s);
    case ({s[2] ^ s[6], s[1] ^ s[4], s[0]})
      3'h1, 3'h5: return `SYM_POS1;
      3'h2: return `SYM_POS2;
      3'h6: return `SYM_NEG2;
      3'h3, 3'h7: return `SYM_NEG1;
      default: return `SYM_ZERO;
    endcase
  endfunction
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_mode(input logic [2:0] m);
    mgmt_mode = m;
    step(2);
  endtask
  task automatic test_alt(input logic [2:0] m, input logic exp_master);
    logic c;
    c = clk_out;
    set_mode(m);
    check({11'h0, active}, 12'h1);
    for (int i = 0; i < 6; i++)
    begin
      check({11'h0, clk_out}, {11'h0, c ^ (i % 2 == 1)});
      check(tx_sym, quad(i % 2 ? `SYM_NEG2 : `SYM_POS2));
      check({11'h0, master}, {11'h0, exp_master});
      check({11'h0, pairs_equal}, 12'h1);
      step(1);
    end
    $display("alternating mode %0d done", m);
  endtask
  task automatic test_t1();
    set_mode(`MODE_TEST1);
    for (int i = 0; i < 34; i++)
    begin
      check(tx_sym, quad(t1_sym(i % 16)));
      check({11'h0, master}, 12'h1);
      step(1);
    end
    $display("mode 1 done");
  endtask
  task automatic test_t4();
    set_mode(`MODE_TEST4);
    scr = `SCR_SEED;
    for (int i = 0; i < 40; i++)
    begin
      check(tx_sym, quad(scr_sym(scr)));
      check({11'h0, master}, 12'h1);
      scr = {scr[9:0], scr[`SCR_TAP_A] ^ scr[`SCR_TAP_B]};
      step(1);
    end
    $display("mode 4 done");
  endtask
  task automatic test_normal();
    logic [2:0] codes [3] = '{3'h0, 3'h5, 3'h7};
    for (int i = 0; i < 3; i++)
    begin
      norm_sym = (i == 1) ? 12'h3B1 : 12'h1CA;
      norm_master = (i == 1);
      set_mode(codes[i]);
      step(1);
      check(tx_sym, norm_sym);
      check({11'h0, master}, {11'h0, norm_master});
      check({11'h0, active}, 12'h0);
      check({11'h0, reserved}, {11'h0, i != 0});
    end
    $display("normal and reserved done");
  endtask
  task automatic test_pins();
    pin_sel = `MODE_TEST2;
    pin_en = 1'b1;
    for (int n = 0; n < 10 && pin_sym !== quad(`SYM_POS2); n++) step(1);
    for (int n = 0; n < 4; n++)
    begin
      check(pin_sym, quad(n % 2 ? `SYM_NEG2 : `SYM_POS2));
      step(1);
    end
    pin_en = 1'b0;
    $display("pin control done");
  endtask
  task automatic test_clk_out();
    logic c;
    step(4);
    check({11'h0, clk_out}, 12'h0);
    pin_clk_en = 1'b1;
    step(5);
    c = clk_out;
    step(1);
    check({11'h0, clk_out}, {11'h0, ~c});
    step(1);
    check({11'h0, clk_out}, {11'h0, c});
    $display("clock output done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // reset, then every scenario in turn
  initial
  begin
    rst_n = 1'b0;
    mgmt_mode = 3'h0;
    pin_en = 1'b0;
    pin_sel = 3'h0;
    pin_clk_en = 1'b0;
    norm_master = 1'b0;
    norm_sym = 12'h1CA;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(1);
    test_clk_out();
    test_alt(`MODE_TEST2, 1'b1);
    test_alt(`MODE_TEST3, 1'b0);
    test_t1();
    test_t4();
    test_normal();
    test_pins();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
